// >>> hdl/vtg_pkg.sv
// types shared by the video timing generator files
// assumes vtg_regs.svh is on the include path
package vtg_pkg;
  // selector codes held in the pin routing fields
  typedef enum logic [3:0] {
    VTG_SEL_HSYNC = 4'h0,
    VTG_SEL_HBLANK = 4'h1,
    VTG_SEL_VSYNC = 4'h2,
    VTG_SEL_VBLANK = 4'h3,
    VTG_SEL_REFERENCE_FIELD_SYNC_IN = 4'h4,
    VTG_SEL_FDIG = 4'h5,
    VTG_SEL_LOW = 4'hf
  } vtg_sel_t;
  typedef logic [15:0] vtg_cnt_t;
endpackage

// >>> hdl/vtg_ref_sync.sv
// two-flop synchroniser for the three reference sync inputs
// assumes the inputs are asynchronous pins; reset sets them inactive (high)
`timescale 1ns/1ps
module vtg_ref_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 3'h7;
      sync_ff <= 3'h7;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// >>> hdl/vtg_regs.svh
// register indices, field positions, reset values and codes of the video timing generator
// assumes a 32-bit AXI4-Lite bus; byte address of a register is four times its index
`ifndef VTG_REGS_SVH
`define VTG_REGS_SVH

// ************************************************************
// register indices
// ************************************************************
`define VTG_IDX_CTRL 10'h000
`define VTG_IDX_HLINE 10'h001
`define VTG_IDX_HSYNC 10'h002
`define VTG_IDX_VFRAME 10'h003
`define VTG_IDX_VSYNC 10'h004
`define VTG_IDX_VFIELD 10'h005
`define VTG_IDX_STATUS 10'h006
`define VTG_IDX_GL_PIX 10'h01b
`define VTG_IDX_GL_LINE 10'h01c
`define VTG_IDX_ROUTE_LO 10'h043
`define VTG_IDX_ROUTE_HI 10'h044
`define VTG_IDX_POLARITY 10'h056

// ************************************************************
// reset values
// ************************************************************
`define VTG_RST_CTRL 32'h0000_0000
`define VTG_RST_HLINE 32'h0780_0898
`define VTG_RST_HSYNC 32'h00c0_002c
`define VTG_RST_VFRAME 32'h0438_0465
`define VTG_RST_VSYNC 32'h0029_0005
`define VTG_RST_VFIELD 32'h0000_0233
`define VTG_RST_GL 16'h0000
`define VTG_RST_ROUTE_LO 16'h3210
`define VTG_RST_ROUTE_HI 16'hff54
`define VTG_RST_POLARITY 16'h0000

// ************************************************************
// field positions
// ************************************************************
`define VTG_CTRL_STD 5:0
`define VTG_CTRL_GENLOCK 8
`define VTG_CTRL_INTERLACE 9
`define VTG_LO_HALF 15:0
`define VTG_HI_HALF 31:16
`define VTG_POL_HSYNC 0
`define VTG_POL_HBLANK 1
`define VTG_POL_VSYNC 2
`define VTG_POL_VBLANK 3
`define VTG_POL_REFERENCE_FIELD_SYNC_IN 4
`define VTG_POL_FDIG 5

// ************************************************************
// codes and constants
// ************************************************************
`define VTG_STD_A 6'h04
`define VTG_STD_B 6'h06
`define VTG_STD_C 6'h08
`define VTG_VB_F1_LONGER 16'h0002
`define VTG_VB_F2_SHORTER 16'h0001
`define VTG_ONE 16'h0001
`define VTG_ZERO16 16'h0000
`define VTG_RESP_OKAY 2'b00
`define VTG_RESP_SLVERR 2'b10
`define VTG_ROUTE_W 4

`endif

// >>> hdl/vtg_top.sv
// video timing output generator with AXI4-Lite register slave
// assumes one clock aclk for bus and pixel timing, synchronous active-low reset
`timescale 1ns/1ps
`include "vtg_regs.svh"
module vtg_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reference_hsync_in_n,
  input wire logic reference_vsync_in_n,
  input wire logic reference_field_sync_in,
  output logic [7:0] timing_out,
  output vtg_pkg::vtg_cnt_t line_count
);
  import vtg_pkg::*;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [9:0] idx);
    return (idx == `VTG_IDX_CTRL) || (idx == `VTG_IDX_HLINE) || (idx == `VTG_IDX_HSYNC) ||
           (idx == `VTG_IDX_VFRAME) || (idx == `VTG_IDX_VSYNC) || (idx == `VTG_IDX_VFIELD) ||
           (idx == `VTG_IDX_STATUS) || (idx == `VTG_IDX_GL_PIX) || (idx == `VTG_IDX_GL_LINE) ||
           (idx == `VTG_IDX_ROUTE_LO) || (idx == `VTG_IDX_ROUTE_HI) || (idx == `VTG_IDX_POLARITY);
  endfunction

  function automatic logic route_bit(input logic [3:0] sel, input logic [5:0] sigs);
    logic res;
    res = 1'b0;
    case (sel)
      VTG_SEL_HSYNC: res = sigs[0];
      VTG_SEL_HBLANK: res = sigs[1];
      VTG_SEL_VSYNC: res = sigs[2];
      VTG_SEL_VBLANK: res = sigs[3];
      VTG_SEL_REFERENCE_FIELD_SYNC_IN: res = sigs[4];
      VTG_SEL_FDIG: res = sigs[5];
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // ************************************************************
  // register file
  // ************************************************************
  logic [31:0] ctrl_ff;
  logic [31:0] hline_ff;
  logic [31:0] hsync_ff;
  logic [31:0] vframe_ff;
  logic [31:0] vsync_ff;
  logic [31:0] vfield_ff;
  logic [15:0] gl_pix_ff;
  logic [15:0] gl_line_ff;
  logic [15:0] route_lo_ff;
  logic [15:0] route_hi_ff;
  logic [15:0] polarity_ff;

  // write channel holding
  logic aw_hold_ff;
  logic [9:0] aw_idx_ff;
  logic w_hold_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_hold_ff || aw_take;
  wire have_w = w_hold_ff || w_take;
  wire do_write = have_aw && have_w && !bvalid_ff;
  wire [9:0] wr_idx = aw_hold_ff ? aw_idx_ff : s_axi_awaddr[11:2];
  wire [31:0] wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire rd_take = s_axi_arvalid && s_axi_arready;

  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire we_ctrl = do_write && (wr_idx == `VTG_IDX_CTRL);
  wire we_hline = do_write && (wr_idx == `VTG_IDX_HLINE);
  wire we_hsync = do_write && (wr_idx == `VTG_IDX_HSYNC);
  wire we_vframe = do_write && (wr_idx == `VTG_IDX_VFRAME);
  wire we_vsync = do_write && (wr_idx == `VTG_IDX_VSYNC);
  wire we_vfield = do_write && (wr_idx == `VTG_IDX_VFIELD);
  wire we_gl_pix = do_write && (wr_idx == `VTG_IDX_GL_PIX);
  wire we_gl_line = do_write && (wr_idx == `VTG_IDX_GL_LINE);
  wire we_route_lo = do_write && (wr_idx == `VTG_IDX_ROUTE_LO);
  wire we_route_hi = do_write && (wr_idx == `VTG_IDX_ROUTE_HI);
  wire we_polarity = do_write && (wr_idx == `VTG_IDX_POLARITY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_idx_ff <= 10'h000;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `VTG_RESP_OKAY;
    end else if (do_write) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff <= is_mapped(wr_idx) ? `VTG_RESP_OKAY : `VTG_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_hold_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // defaults come from the reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `VTG_RST_CTRL;
      hline_ff <= `VTG_RST_HLINE;
      hsync_ff <= `VTG_RST_HSYNC;
      vframe_ff <= `VTG_RST_VFRAME;
      vsync_ff <= `VTG_RST_VSYNC;
      vfield_ff <= `VTG_RST_VFIELD;
      gl_pix_ff <= `VTG_RST_GL;
      gl_line_ff <= `VTG_RST_GL;
      route_lo_ff <= `VTG_RST_ROUTE_LO;
      route_hi_ff <= `VTG_RST_ROUTE_HI;
      polarity_ff <= `VTG_RST_POLARITY;
    end else begin
      if (we_ctrl) ctrl_ff <= merge_strb(ctrl_ff, wr_data, wr_strb);
      if (we_hline) hline_ff <= merge_strb(hline_ff, wr_data, wr_strb);
      if (we_hsync) hsync_ff <= merge_strb(hsync_ff, wr_data, wr_strb);
      if (we_vframe) vframe_ff <= merge_strb(vframe_ff, wr_data, wr_strb);
      if (we_vsync) vsync_ff <= merge_strb(vsync_ff, wr_data, wr_strb);
      if (we_vfield) vfield_ff <= merge_strb(vfield_ff, wr_data, wr_strb);
      if (we_gl_pix) gl_pix_ff <= 16'(merge_strb(32'(gl_pix_ff), wr_data, wr_strb));
      if (we_gl_line) gl_line_ff <= 16'(merge_strb(32'(gl_line_ff), wr_data, wr_strb));
      if (we_route_lo) route_lo_ff <= 16'(merge_strb(32'(route_lo_ff), wr_data, wr_strb));
      if (we_route_hi) route_hi_ff <= 16'(merge_strb(32'(route_hi_ff), wr_data, wr_strb));
      if (we_polarity) polarity_ff <= 16'(merge_strb(32'(polarity_ff), wr_data, wr_strb));
    end
  end

  // ************************************************************
  // timing parameters
  // ************************************************************
  wire [5:0] std_code = ctrl_ff[`VTG_CTRL_STD];
  wire genlock_en = ctrl_ff[`VTG_CTRL_GENLOCK];
  wire interlaced = ctrl_ff[`VTG_CTRL_INTERLACE];
  wire [15:0] h_total = hline_ff[`VTG_LO_HALF];
  wire [15:0] h_active = hline_ff[`VTG_HI_HALF];
  wire [15:0] hs_width = hsync_ff[`VTG_LO_HALF];
  wire [15:0] h_act_start = hsync_ff[`VTG_HI_HALF];
  wire [15:0] v_total = vframe_ff[`VTG_LO_HALF];
  wire [15:0] v_active = vframe_ff[`VTG_HI_HALF];
  wire [15:0] vs_width = vsync_ff[`VTG_LO_HALF];
  wire [15:0] v_act_start = vsync_ff[`VTG_HI_HALF];
  wire [15:0] f2_start = vfield_ff[`VTG_LO_HALF];
  wire odd_std = (std_code == `VTG_STD_A) || (std_code == `VTG_STD_B) || (std_code == `VTG_STD_C);

  // ************************************************************
  // reference inputs
  // ************************************************************
  logic [2:0] ref_sync;
  logic ref_h_prev_ff;
  logic ref_v_prev_ff;

  vtg_ref_sync u_ref_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({reference_field_sync_in, reference_vsync_in_n, reference_hsync_in_n}),
    .sync_out(ref_sync)
  );

  // references are active low; leading edge is the fall
  wire ref_h_lead = genlock_en && ref_h_prev_ff && !ref_sync[0];
  wire ref_v_lead = genlock_en && ref_v_prev_ff && !ref_sync[1];
  wire ref_field1 = ref_sync[2];

  // ************************************************************
  // counters
  // ************************************************************
  vtg_cnt_t hcnt_ff;
  vtg_cnt_t vcnt_ff;
  logic vb_ff;
  logic fdig_ff;

  wire h_last = (hcnt_ff == (h_total - `VTG_ONE));
  wire v_last = (vcnt_ff == (v_total - `VTG_ONE));
  wire [15:0] v_step = v_last ? `VTG_ZERO16 : vcnt_ff + `VTG_ONE;
  wire [15:0] v_lock = (interlaced && !ref_field1) ? f2_start + gl_line_ff : gl_line_ff;
  wire [15:0] nxt_hcnt = ref_h_lead ? gl_pix_ff : (h_last ? `VTG_ZERO16 : hcnt_ff + `VTG_ONE);
  wire [15:0] nxt_vcnt = ref_v_lead ? v_lock : (h_last ? v_step : vcnt_ff);

  // locked counters carry every output, so all genlocked signals share one offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcnt_ff <= `VTG_ZERO16;
      vcnt_ff <= `VTG_ZERO16;
      ref_h_prev_ff <= 1'b1;
      ref_v_prev_ff <= 1'b1;
    end else begin
      hcnt_ff <= nxt_hcnt;
      vcnt_ff <= nxt_vcnt;
      ref_h_prev_ff <= ref_sync[0];
      ref_v_prev_ff <= ref_sync[1];
    end
  end

  // ************************************************************
  // raw timing signals, active high
  // ************************************************************
  wire field2 = interlaced && (vcnt_ff >= f2_start);
  wire [15:0] lf = field2 ? vcnt_ff - f2_start : vcnt_ff;
  wire [15:0] h_act_end = h_act_start + h_active;
  wire hs_raw = (hcnt_ff < hs_width);
  wire hb_raw = !((hcnt_ff >= h_act_start) && (hcnt_ff < h_act_end));
  wire vs_raw = (lf < vs_width);
  // shortening field two below line zero is not guarded; keep the start at one or more
  wire [15:0] v_adj_start = !odd_std ? v_act_start :
                            (field2 ? v_act_start - `VTG_VB_F2_SHORTER : v_act_start + `VTG_VB_F1_LONGER);
  wire [15:0] v_act_end = v_act_start + v_active;
  wire vb_raw = !((lf >= v_adj_start) && (lf < v_act_end));
  // field identity is fixed at line zero of a field, which is the frame sync leading edge
  wire fs_raw = interlaced && !field2;
  wire vb_lead = vb_raw && !vb_ff;
  wire nxt_fdig = !interlaced ? 1'b0 : (vb_lead ? !field2 : fdig_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vb_ff <= 1'b1;
      fdig_ff <= 1'b0;
    end else begin
      vb_ff <= vb_raw;
      fdig_ff <= nxt_fdig;
    end
  end

  // ************************************************************
  // polarity and routing
  // ************************************************************
  wire hs_out = polarity_ff[`VTG_POL_HSYNC] ? hs_raw : !hs_raw;
  wire hb_out = hb_raw ^ polarity_ff[`VTG_POL_HBLANK];
  wire vs_out = polarity_ff[`VTG_POL_VSYNC] ? vs_raw : !vs_raw;
  wire vb_out = vb_raw ^ polarity_ff[`VTG_POL_VBLANK];
  wire fs_out = fs_raw ^ polarity_ff[`VTG_POL_REFERENCE_FIELD_SYNC_IN];
  wire fd_out = nxt_fdig ^ polarity_ff[`VTG_POL_FDIG];
  wire [5:0] sig_vec = {fd_out, fs_out, vb_out, vs_out, hb_out, hs_out};
  wire [31:0] route_all = {route_hi_ff, route_lo_ff};
  logic [7:0] nxt_tout;
  logic [7:0] tout_ff;

  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_pin
      assign nxt_tout[p] = route_bit(route_all[p*`VTG_ROUTE_W +: `VTG_ROUTE_W], sig_vec);
    end
  endgenerate

  // one register stage on every pin keeps the pins aligned to each other
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tout_ff <= 8'h00;
    end else begin
      tout_ff <= nxt_tout;
    end
  end

  assign timing_out = tout_ff;
  assign line_count = vcnt_ff;

  // ************************************************************
  // read channel
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_idx)
      `VTG_IDX_CTRL: rd_mux = ctrl_ff;
      `VTG_IDX_HLINE: rd_mux = hline_ff;
      `VTG_IDX_HSYNC: rd_mux = hsync_ff;
      `VTG_IDX_VFRAME: rd_mux = vframe_ff;
      `VTG_IDX_VSYNC: rd_mux = vsync_ff;
      `VTG_IDX_VFIELD: rd_mux = vfield_ff;
      `VTG_IDX_STATUS: rd_mux = {14'h0000, fdig_ff, field2, vcnt_ff};
      `VTG_IDX_GL_PIX: rd_mux = {16'h0000, gl_pix_ff};
      `VTG_IDX_GL_LINE: rd_mux = {16'h0000, gl_line_ff};
      `VTG_IDX_ROUTE_LO: rd_mux = {16'h0000, route_lo_ff};
      `VTG_IDX_ROUTE_HI: rd_mux = {16'h0000, route_hi_ff};
      `VTG_IDX_POLARITY: rd_mux = {16'h0000, polarity_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `VTG_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= is_mapped(rd_idx) ? `VTG_RESP_OKAY : `VTG_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// >>> tb/vtg_ref_src.sv
// reference sync source standing where the house sync would be
// assumes the reference runs on aclk; lines idle inactive high when stopped
`timescale 1ns/1ps
module vtg_ref_src (
  input wire logic aclk,
  input wire logic run,
  input wire logic [15:0] period,
  output logic ref_h_n,
  output logic ref_v_n,
  output logic ref_f
);
  // ************************************************************
  // line reference, four clocks low per period
  // ************************************************************
  logic [15:0] cnt_ff = 16'h0000;
  initial ref_h_n = 1'b1;
  // no frame reference here, so vertical and field inputs rest at their idle level
  assign ref_v_n = 1'b1;
  assign ref_f = 1'b1;
  always @(posedge aclk) begin
    if (!run || cnt_ff == period - 16'h0001) cnt_ff <= 16'h0000;
    else cnt_ff <= cnt_ff + 16'h0001;
    ref_h_n <= !(run && cnt_ff < 16'h0004);
  end
endmodule

// >>> tb/vtg_top_chk.sv
// assertions on the bus handshakes and timing pins of vtg_top
// assumes a bind into vtg_top; pin checks only while routing and polarity keep their reset values
`timescale 1ns/1ps
`include "vtg_regs.svh"
module vtg_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] timing_out
);
  // ************************************************************
  // helper state and properties
  // ************************************************************
  logic dflt_ff;
  logic [9:0] quiet_ff;
  wire wr_hs = s_axi_awvalid && s_axi_awready;
  wire [9:0] wr_idx = s_axi_awaddr[11:2];
  wire map_wr = wr_hs && (wr_idx == `VTG_IDX_POLARITY || wr_idx == `VTG_IDX_ROUTE_LO || wr_idx == `VTG_IDX_ROUTE_HI);
  // a write may move edges off their causes, so pin checks wait 1023 cycles after it
  wire calm = dflt_ff && quiet_ff == 10'h3ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dflt_ff <= 1'b1;
      quiet_ff <= 10'h000;
    end else begin
      if (map_wr) dflt_ff <= 1'b0;
      if (wr_hs) quiet_ff <= 10'h000;
      else if (quiet_ff != 10'h3ff) quiet_ff <= quiet_ff + 10'h001;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("bvalid late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("rvalid late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready during rvalid");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write ready during bvalid");
  property p_first;
    $rose(aresetn) |-> timing_out == 8'h00 ##1 timing_out == 8'h0a;
  endproperty
  a_first: assert property (p_first) else $error("pins wrong after reset");
  property p_reference_field_sync_in;
    calm && $changed(timing_out[4]) |-> $fell(timing_out[2]);
  endproperty
  a_reference_field_sync_in: assert property (p_reference_field_sync_in) else $error("field sync moved off frame sync");
  property p_fdig;
    calm && $changed(timing_out[5]) |-> $rose(timing_out[3]);
  endproperty
  a_fdig: assert property (p_fdig) else $error("field flag moved off blanking");
endmodule

bind vtg_top vtg_top_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .timing_out);

// >>> tb/vtg_top_tb.sv
// self-checking bench of vtg_top: register access, pin timing, polarity, routing, line lock
// assumes vtg_ref_src drives the reference pins and vtg_top_chk is bound in
`timescale 1ns/1ps
`include "vtg_regs.svh"
module vtg_top_tb;
  import vtg_pkg::*;
  localparam int HT = 40, HA = 20, HW = 4, VT = 20, VF = 10, VW = 2, VAS = 4, N = HT * VT;
  logic aclk = 1'b0, aresetn = 1'b0, ref_run = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reference_hsync_in_n, reference_vsync_in_n, reference_field_sync_in;
  logic [7:0] timing_out;
  vtg_cnt_t line_count;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #25 aclk = ~aclk;
  vtg_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reference_hsync_in_n,
    .reference_vsync_in_n, .reference_field_sync_in, .timing_out, .line_count);
  vtg_ref_src ref_src (.aclk, .run(ref_run), .period(16'h0028), .ref_h_n(reference_hsync_in_n),
    .ref_v_n(reference_vsync_in_n), .ref_f(reference_field_sync_in));
  // ************************************************************
  // checks and bus tasks
  // ************************************************************
  task automatic close_out;
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input string what);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit ha, hw, bv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!bv);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ha, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end while (!rv);
    s_axi_rready <= 1'b0;
  endtask
  task automatic put(input logic [9:0] i, input logic [31:0] d);
    logic [1:0] r;
    wr({i, 2'b00}, d, 4'hf, r);
    chk32({30'h0, r}, 32'h0, "bresp");
  endtask
  task automatic get(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd({i, 2'b00}, d, r);
    chk32(d, e, "rdata");
    chk32({30'h0, r}, {30'h0, er}, "rresp");
  endtask
  // ************************************************************
  // expectations
  // ************************************************************
  function automatic logic [31:0] merge16(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    return {16'h0, s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction
  // high cycles per pin over one frame at default polarity; second pass is the steady one
  function automatic void expect_hi(input bit il, input bit adj, input int val, output int e[8]);
    int lf, st, v;
    bit f2, vb, vbp, fd;
    e = '{default: 0};
    vbp = 1'b1;
    fd = 1'b0;
    for (int p = 0; p < 2 * VT; p++) begin
      v = p % VT;
      f2 = il && v >= VF;
      lf = f2 ? v - VF : v;
      st = adj ? (f2 ? VAS - 1 : VAS + 2) : VAS;
      vb = !(lf >= st && lf < VAS + val);
      if (vb && !vbp) fd = il && !f2;
      vbp = vb;
      if (p >= VT) begin
        e[0] += HT - HW;
        e[1] += HT - HA;
        e[2] += lf < VW ? 0 : HT;
        e[3] += vb ? HT : 0;
        e[4] += il && !f2 ? HT : 0;
        e[5] += fd ? HT : 0;
      end
    end
  endfunction
  task automatic check_frame(input bit il, input bit adj, input bit inv, input bit rt, input int val);
    int c[8], e[8], z;
    repeat (N) @(posedge aclk);
    expect_hi(il, adj, val, e);
    for (int k = 0; k < 6; k++) if (inv) e[k] = N - e[k];
    if (rt) e[6] = e[0];
    if (rt) e[7] = e[1];
    c = '{default: 0};
    z = 0;
    repeat (N) begin
      @(posedge aclk);
      #1;
      z += (line_count === '0);
      for (int k = 0; k < 8; k++) c[k] += (timing_out[k] === 1'b1);
    end
    chk_n(z, HT, "line zero cycles");
    for (int k = 0; k < 8; k++) chk_n(c[k], e[k], "pin high cycles");
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] d, g;
    logic [31:0] codes[4];
    logic [3:0] s;
    logic [1:0] r;
    logic lv;
    int n;
    codes = '{32'h4, 32'h6, 32'h8, 32'h5};
    d = $urandom(32'h20a6c78e);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    get(`VTG_IDX_ROUTE_LO, 32'h0000_3210, 2'b00);
    get(`VTG_IDX_ROUTE_HI, 32'h0000_ff54, 2'b00);
    get(`VTG_IDX_POLARITY, 32'h0, 2'b00);
    get(`VTG_IDX_GL_PIX, 32'h0, 2'b00);
    get(10'h3ff, 32'h0, 2'b10);
    wr(12'hffc, 32'hffff_ffff, 4'hf, r);
    chk32({30'h0, r}, 32'h2, "unmapped bresp");
    d = 32'h0;
    repeat (8) begin
      g = $urandom;
      s = 4'($urandom);
      wr({`VTG_IDX_GL_LINE, 2'b00}, g, s, r);
      d = merge16(d, g, s);
      get(`VTG_IDX_GL_LINE, d, 2'b00);
    end
    // second reset; shrink raster while counters are low
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    put(`VTG_IDX_HLINE, 32'h0014_0028);
    put(`VTG_IDX_HSYNC, 32'h0008_0004);
    put(`VTG_IDX_VFRAME, 32'h000a_0014);
    put(`VTG_IDX_VSYNC, 32'h0004_0002);
    put(`VTG_IDX_VFIELD, 32'h0000_000a);
    check_frame(0, 0, 0, 0, 10);
    put(`VTG_IDX_VFRAME, 32'h0004_0014);
    foreach (codes[i]) begin
      put(`VTG_IDX_CTRL, 32'h0000_0200 | codes[i]);
      check_frame(1, codes[i] != 32'h5, 0, 0, 4);
    end
    put(`VTG_IDX_POLARITY, 32'h0000_003f);
    put(`VTG_IDX_ROUTE_HI, 32'h0000_1054);
    check_frame(1, 0, 1, 1, 4);
    put(`VTG_IDX_POLARITY, 32'h0);
    put(`VTG_IDX_CTRL, 32'h0000_0100);
    ref_run <= 1'b1;
    for (int p = 0; p < 8; p += 7) begin
      put(`VTG_IDX_GL_PIX, 32'(p));
      repeat (3 * HT) @(posedge aclk);
      @(negedge reference_hsync_in_n);
      #1;
      n = 0;
      lv = timing_out[0];
      while (!(lv === 1'b1 && timing_out[0] === 1'b0) && n < 100) begin
        lv = timing_out[0];
        @(posedge aclk);
        #1;
        n++;
      end
      chk_n(n, (HT - p) % HT + 4, "line lock delay");
    end
    close_out();
  end
endmodule
